// ### rtl/fifo_trig_regs.sv
// register bank for trigger levels, fifo ready status and gated extended registers
`timescale 1ns/1ps
module fifo_trig_regs (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [1:0] chan_sel_n,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  input wire fifo_trig_pkg::fifo_level_t [1:0] fifo_level,
  output logic [1:0] prescale_alt,
  output logic [15:0] divisor_a,
  output logic [15:0] divisor_b,
  output logic [7:0] flow_thresholds_a,
  output logic [7:0] flow_thresholds_b,
  output logic [6:0] tx_trig_a,
  output logic [6:0] rx_trig_a,
  output logic [6:0] tx_trig_b,
  output logic [6:0] rx_trig_b
);
  fifo_trig_pkg::chan_regs_t [1:0] regs_q;
  fifo_trig_pkg::chan_regs_t [1:0] regs_d;
  logic [2:0] addr_s1_q;
  logic [2:0] addr_s_q;
  logic [1:0] cs_s1_q;
  logic [1:0] cs_n_s_q;
  logic wr_s1_q;
  logic wr_s_q;
  logic wr_prev_q;
  logic rd_s1_q;
  logic rd_s_q;
  logic [7:0] wd_s1_q;
  logic [7:0] wd_s_q;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic [7:0] ready_byte;
  logic [6:0] tx_lvl [2];
  logic [6:0] rx_lvl [2];
  logic [1:0] tx_rdy;
  logic [1:0] rx_rdy;
  logic wr_pulse;

  // two-stage synchronisers for bus pins
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      addr_s1_q <= 3'h0;
      addr_s_q <= 3'h0;
      cs_s1_q <= 2'h3;
      cs_n_s_q <= 2'h3;
      wr_s1_q <= 1'b0;
      wr_s_q <= 1'b0;
      wr_prev_q <= 1'b0;
      rd_s1_q <= 1'b0;
      rd_s_q <= 1'b0;
      wd_s1_q <= 8'h00;
      wd_s_q <= 8'h00;
    end
    else
    begin
      addr_s1_q <= addr;
      addr_s_q <= addr_s1_q;
      cs_s1_q <= chan_sel_n;
      cs_n_s_q <= cs_s1_q;
      wr_s1_q <= wr_stb;
      wr_s_q <= wr_s1_q;
      wr_prev_q <= wr_s_q;
      rd_s1_q <= rd_stb;
      rd_s_q <= rd_s1_q;
      wd_s1_q <= wr_data;
      wd_s_q <= wd_s1_q;
    end
  end

  assign wr_pulse = wr_s_q && !wr_prev_q;

  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    trig_select u_tx (
      .trig_field(regs_q[c].fifo_trigger_levels[3:0]),
      .ctrl_sel(regs_q[c].fifo_control[5:4]),
      .level(fifo_level[c].tx_free),
      .is_tx(1'b1),
      .rx_timeout(1'b0),
      .active_level(tx_lvl[c]),
      .ready(tx_rdy[c])
    );
    trig_select u_rx (
      .trig_field(regs_q[c].fifo_trigger_levels[7:4]),
      .ctrl_sel(regs_q[c].fifo_control[7:6]),
      .level(fifo_level[c].rx_count),
      .is_tx(1'b0),
      .rx_timeout(fifo_level[c].rx_timeout),
      .active_level(rx_lvl[c]),
      .ready(rx_rdy[c])
    );
  end

  assign ready_byte = {2'b00, rx_rdy, 2'b00, tx_rdy};

  always_comb
  begin
    logic enh;
    logic ext;
    logic divk;
    logic bfk;
    enh = 1'b0;
    ext = 1'b0;
    divk = 1'b0;
    bfk = 1'b0;
    regs_d = regs_q;
    for (int c = 0; c < 2; c++)
    begin
      enh = regs_q[c].enhanced_feature_ctrl[fifo_trig_pkg::ENH_ENABLE_BIT];
      ext = regs_q[c].modem_control[fifo_trig_pkg::MODEM_EXT_BIT];
      bfk = (regs_q[c].line_control == fifo_trig_pkg::LINE_EXT_KEY);
      divk = regs_q[c].line_control[7] && !bfk;
      if (wr_pulse && !cs_n_s_q[c])
      begin
        case (addr_s_q)
          fifo_trig_pkg::ADDR_DIV_LOW:
          begin
            if (divk)
              regs_d[c].divisor_low = wd_s_q;
          end
          fifo_trig_pkg::ADDR_DIV_HIGH:
          begin
            if (divk)
              regs_d[c].divisor_high = wd_s_q;
            else if (!bfk)
              regs_d[c].int_enable = enh ? wd_s_q :
                ((wd_s_q & ~fifo_trig_pkg::IER_PROT_MASK) |
                 (regs_q[c].int_enable & fifo_trig_pkg::IER_PROT_MASK));
          end
          fifo_trig_pkg::ADDR_ENH:
          begin
            if (bfk)
              regs_d[c].enhanced_feature_ctrl = wd_s_q;
            else if (!divk)
              regs_d[c].fifo_control = enh ? wd_s_q :
                ((wd_s_q & ~fifo_trig_pkg::FIFO_CTRL_PROT_MASK) |
                 (regs_q[c].fifo_control & fifo_trig_pkg::FIFO_CTRL_PROT_MASK));
          end
          fifo_trig_pkg::ADDR_LINE: regs_d[c].line_control = wd_s_q;
          fifo_trig_pkg::ADDR_MODEM:
          begin
            if (bfk)
              regs_d[c].resume_char_one = wd_s_q;
            else
              regs_d[c].modem_control = enh ? wd_s_q :
                ((wd_s_q & ~fifo_trig_pkg::MODEM_PROT_MASK) |
                 (regs_q[c].modem_control & fifo_trig_pkg::MODEM_PROT_MASK));
          end
          fifo_trig_pkg::ADDR_X5:
          begin
            if (bfk)
              regs_d[c].resume_char_two = wd_s_q;
          end
          fifo_trig_pkg::ADDR_X6:
          begin
            if (bfk)
              regs_d[c].stop_char_one = wd_s_q;
            else if (enh && ext)
              regs_d[c].flow_threshold_ctrl = wd_s_q;
          end
          default:
          begin
            if (bfk)
              regs_d[c].stop_char_two = wd_s_q;
            else if (enh && ext)
              regs_d[c].fifo_trigger_levels = wd_s_q;
          end
        endcase
      end
    end
  end
  always_comb
  begin
    logic sel;
    logic bfk;
    logic [7:0] modem_v;
    logic [7:0] line_v;
    sel = cs_n_s_q[0] ? 1'b1 : 1'b0;
    modem_v = regs_q[sel].modem_control;
    line_v = regs_q[sel].line_control;
    bfk = (line_v == fifo_trig_pkg::LINE_EXT_KEY);
    rd_data_d = rd_data_q;
    if (rd_s_q && !(&cs_n_s_q))
    begin
      case (addr_s_q)
        fifo_trig_pkg::ADDR_DIV_LOW:
          rd_data_d = (line_v[7] && !bfk) ? regs_q[sel].divisor_low : 8'h00;
        fifo_trig_pkg::ADDR_DIV_HIGH:
          rd_data_d = (line_v[7] && !bfk) ? regs_q[sel].divisor_high : regs_q[sel].int_enable;
        fifo_trig_pkg::ADDR_ENH: rd_data_d = bfk ? regs_q[sel].enhanced_feature_ctrl : 8'h00;
        fifo_trig_pkg::ADDR_LINE: rd_data_d = line_v;
        fifo_trig_pkg::ADDR_MODEM: rd_data_d = bfk ? regs_q[sel].resume_char_one : modem_v;
        fifo_trig_pkg::ADDR_X5: rd_data_d = bfk ? regs_q[sel].resume_char_two : 8'h00;
        fifo_trig_pkg::ADDR_X6:
          rd_data_d = bfk ? regs_q[sel].stop_char_one : regs_q[sel].flow_threshold_ctrl;
        fifo_trig_pkg::ADDR_X7:
        begin
          if (bfk)
            rd_data_d = regs_q[sel].stop_char_two;
          else if (modem_v[fifo_trig_pkg::MODEM_RDY_EN_BIT] &&
            !modem_v[fifo_trig_pkg::MODEM_LOOP_BIT])
            rd_data_d = ready_byte;
          else
            rd_data_d = regs_q[sel].fifo_trigger_levels;
        end
        default: rd_data_d = 8'h00;
      endcase
    end
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (int c = 0; c < 2; c++)
      begin
        regs_q[c] <= '0;
        regs_q[c].divisor_low <= fifo_trig_pkg::RESET_DIV;
      end
      rd_data_q <= fifo_trig_pkg::RESET_BYTE;
    end
    else
    begin
      regs_q <= regs_d;
      rd_data_q <= rd_data_d;
    end
  end
  assign rd_data = rd_data_q;
  assign prescale_alt = {regs_q[1].modem_control[fifo_trig_pkg::MODEM_PRESCALE_BIT],
    regs_q[0].modem_control[fifo_trig_pkg::MODEM_PRESCALE_BIT]};
  assign divisor_a = {regs_q[0].divisor_high, regs_q[0].divisor_low};
  assign divisor_b = {regs_q[1].divisor_high, regs_q[1].divisor_low};
  assign flow_thresholds_a = regs_q[0].flow_threshold_ctrl;
  assign flow_thresholds_b = regs_q[1].flow_threshold_ctrl;
  assign tx_trig_a = tx_lvl[0];
  assign rx_trig_a = rx_lvl[0];
  assign tx_trig_b = tx_lvl[1];
  assign rx_trig_b = rx_lvl[1];
  default clocking main_cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic rdy_read_a;
  assign rdy_read_a = rd_s_q && !cs_n_s_q[0] && addr_s_q == fifo_trig_pkg::ADDR_X7 &&
    regs_q[0].line_control != fifo_trig_pkg::LINE_EXT_KEY &&
    regs_q[0].modem_control[fifo_trig_pkg::MODEM_RDY_EN_BIT] &&
    !regs_q[0].modem_control[fifo_trig_pkg::MODEM_LOOP_BIT];
  property p_trig_guard;
    !(regs_q[0].enhanced_feature_ctrl[fifo_trig_pkg::ENH_ENABLE_BIT] &&
      regs_q[0].modem_control[fifo_trig_pkg::MODEM_EXT_BIT]) |=>
      $stable(regs_q[0].fifo_trigger_levels);
  endproperty
  a_trig_guard: assert property (p_trig_guard) else $error("trigger register changed");
  property p_ready_zero;
    rdy_read_a |=> rd_data_q[3:2] == 2'b00 && rd_data_q[7:6] == 2'b00;
  endproperty
  a_ready_zero: assert property (p_ready_zero) else $error("unused ready bits set");
  property p_ready_read;
    rdy_read_a |=> rd_data_q == $past(ready_byte);
  endproperty
  a_ready_read: assert property (p_ready_read) else $error("ready status not read");
  property p_modem_prot;
    !regs_q[0].enhanced_feature_ctrl[fifo_trig_pkg::ENH_ENABLE_BIT] |=>
      $stable(regs_q[0].modem_control[7:5]);
  endproperty
  a_modem_prot: assert property (p_modem_prot) else $error("modem bits changed");
  property p_fifo_ctrl_prot;
    !regs_q[0].enhanced_feature_ctrl[fifo_trig_pkg::ENH_ENABLE_BIT] |=>
      $stable(regs_q[0].fifo_control[5:4]);
  endproperty
  a_fifo_ctrl_prot: assert property (p_fifo_ctrl_prot) else $error("fifo bits changed");
  property p_trig_level;
    regs_q[0].fifo_trigger_levels[3:0] != 4'h0 |->
      tx_lvl[0] == {1'b0, regs_q[0].fifo_trigger_levels[3:0], 2'b00};
  endproperty
  a_trig_level: assert property (p_trig_level) else $error("tx level not field");
endmodule : fifo_trig_regs

// ### rtl/fifo_trig_pkg.sv
// shared constants and types for the trigger level and fifo ready register bank
package fifo_trig_pkg;
  localparam logic [2:0] ADDR_DIV_LOW = 3'h0;
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h1;
  localparam logic [2:0] ADDR_ENH = 3'h2;
  localparam logic [2:0] ADDR_LINE = 3'h3;
  localparam logic [2:0] ADDR_MODEM = 3'h4;
  localparam logic [2:0] ADDR_X5 = 3'h5;
  localparam logic [2:0] ADDR_X6 = 3'h6;
  localparam logic [2:0] ADDR_X7 = 3'h7;
  localparam logic [7:0] LINE_DIVISOR_KEY = 8'h80;
  localparam logic [7:0] LINE_EXT_KEY = 8'hBF;
  localparam int ENH_ENABLE_BIT = 4;
  localparam int MODEM_RDY_EN_BIT = 2;
  localparam int MODEM_LOOP_BIT = 4;
  localparam int MODEM_EXT_BIT = 6;
  localparam int MODEM_PRESCALE_BIT = 7;
  localparam logic [7:0] MODEM_PROT_MASK = 8'hE0;
  localparam logic [7:0] IER_PROT_MASK = 8'hF0;
  localparam logic [7:0] FIFO_CTRL_PROT_MASK = 8'h30;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_LINE = 8'h00;
  localparam logic [7:0] RESET_DIV = 8'h01;
  localparam logic [3:0] TRIG_FIELD_OFF = 4'h0;

  typedef struct packed {
    logic [6:0] tx_free;
    logic [6:0] rx_count;
    logic rx_timeout;
  } fifo_level_t;

  typedef struct packed {
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic [7:0] enhanced_feature_ctrl;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] int_enable;
    logic [7:0] fifo_control;
    logic [7:0] resume_char_one;
    logic [7:0] resume_char_two;
    logic [7:0] stop_char_one;
    logic [7:0] stop_char_two;
    logic [7:0] flow_threshold_ctrl;
    logic [7:0] fifo_trigger_levels;
  } chan_regs_t;
endpackage : fifo_trig_pkg

// ### rtl/trig_select.sv
// active trigger level selection and ready flag for one direction (tx or rx) of one channel
`timescale 1ns/1ps
module trig_select (
  input wire logic [3:0] trig_field,
  input wire logic [1:0] ctrl_sel,
  input wire logic [6:0] level,
  input wire logic is_tx,
  input wire logic rx_timeout,
  output logic [6:0] active_level,
  output logic ready
);
  logic [6:0] ctrl_level;
  always_comb
  begin
    case (ctrl_sel)
      2'h0: ctrl_level = is_tx ? 7'h08 : 7'h08;
      2'h1: ctrl_level = is_tx ? 7'h10 : 7'h10;
      2'h2: ctrl_level = is_tx ? 7'h20 : 7'h38;
      default: ctrl_level = is_tx ? 7'h38 : 7'h3C;
    endcase
    if (trig_field == fifo_trig_pkg::TRIG_FIELD_OFF)
      active_level = ctrl_level;
    else
      active_level = {1'b0, trig_field, 2'b00};
    if (is_tx)
      ready = (level >= active_level);
    else
      ready = (level > active_level) || rx_timeout;
  end
endmodule : trig_select

// ### verif/host_bus.sv
// host processor model driving the parallel register bus
`timescale 1ns/1ps
module host_bus (
  input wire logic mclk,
  output logic [2:0] addr,
  output logic [1:0] chan_sel_n,
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);
  initial
  begin
    addr = 3'h0;
    chan_sel_n = 2'h3;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    wr_data = 8'h00;
  end

  // strobe high 4 edges, then low 3 edges with address, data and select held
  task automatic access(input logic [1:0] cs, input logic [2:0] a, input logic [7:0] d,
                        input logic rd, output logic [7:0] q);
    @(posedge mclk);
    #1;
    addr = a;
    chan_sel_n = cs;
    wr_data = d;
    wr_stb = ~rd;
    rd_stb = rd;
    repeat (4) @(posedge mclk);
    #1;
    q = rd_data;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    // released lines show a changing pattern
    chan_sel_n = 2'h3;
    addr = ~addr;
    wr_data = ~wr_data;
  endtask : access
endmodule : host_bus

// ### verif/tb_top.sv
// self-checking testbench for the trigger level and fifo ready register bank
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr;
  logic [1:0] chan_sel_n;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  fifo_trig_pkg::fifo_level_t [1:0] fifo_level = '0;
  logic [1:0] prescale_alt;
  logic [15:0] divisor_a;
  logic [7:0] ft_a;
  logic [6:0] tx_a;
  logic [6:0] rx_a;
  logic [15:0] div_b;
  logic [7:0] ft_b;
  logic [6:0] tx_b;
  logic [6:0] rx_b;
  logic [7:0] rv;
  int errors = 0;
  int checked = 0;

  always #5 mclk = ~mclk;

  host_bus host_bus_i (.mclk(mclk), .addr(addr), .chan_sel_n(chan_sel_n), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .wr_data(wr_data), .rd_data(rd_data));

  fifo_trig_regs fifo_trig_regs_i (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .chan_sel_n(chan_sel_n), .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wr_data),
    .rd_data(rd_data), .fifo_level(fifo_level), .prescale_alt(prescale_alt),
    .divisor_a(divisor_a), .divisor_b(div_b), .flow_thresholds_a(ft_a),
    .flow_thresholds_b(ft_b), .tx_trig_a(tx_a), .rx_trig_a(rx_a), .tx_trig_b(tx_b),
    .rx_trig_b(rx_b));

  task automatic w(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    host_bus_i.access(2'h2, a, d, 1'b0, q);
  endtask : w

  task automatic r(input logic [2:0] a, output logic [7:0] q);
    host_bus_i.access(2'h2, a, 8'h00, 1'b1, q);
  endtask : r

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic t_div;
    chk(divisor_a, 16'h0001);
    w(3'h3, 8'h80);
    w(3'h0, 8'h34);
    w(3'h1, 8'h12);
    w(3'h3, 8'h03);
    w(3'h0, 8'h55);
    chk(divisor_a, 16'h1234);
    $display("done t_div");
  endtask : t_div

  task automatic t_gate;
    w(3'h4, 8'hC0);
    w(3'h7, 8'h51);
    chk({9'h000, tx_a}, 16'h0008);
    chk({9'h000, rx_a}, 16'h0008);
    chk({14'h0000, prescale_alt}, 16'h0000);
    $display("done t_gate");
  endtask : t_gate

  task automatic t_ext;
    w(3'h3, 8'hBF);
    for (int i = 4; i < 8; i++)
      w(3'(i), 8'hC0 + 8'(i));
    for (int i = 4; i < 8; i++)
    begin
      r(3'(i), rv);
      chk({8'h00, rv}, 16'h00C0 + 16'(i));
    end
    w(3'h2, 8'h10);
    r(3'h2, rv);
    chk({8'h00, rv}, 16'h0010);
    $display("done t_ext");
  endtask : t_ext

  task automatic t_tlr;
    w(3'h3, 8'h00);
    w(3'h4, 8'h40);
    w(3'h6, 8'hA5);
    chk({8'h00, ft_a}, 16'h00A5);
    w(3'h7, 8'h51);
    chk({9'h000, tx_a}, 16'h0004);
    chk({9'h000, rx_a}, 16'h0014);
    chk(div_b, 16'h0001);
    chk({8'h00, ft_b}, 16'h0000);
    chk({9'h000, tx_b}, 16'h0008);
    chk({9'h000, rx_b}, 16'h0008);
    $display("done t_tlr");
  endtask : t_tlr

  task automatic t_rdy;
    fifo_level[0] = '{tx_free: 7'h04, rx_count: 7'h14, rx_timeout: 1'b0};
    fifo_level[1] = '{tx_free: 7'h07, rx_count: 7'h00, rx_timeout: 1'b1};
    w(3'h4, (8'h40 & 8'hEF) | 8'h04);
    r(3'h7, rv);
    chk({8'h00, rv}, 16'h0021);
    w(3'h4, 8'h54);
    r(3'h7, rv);
    chk({8'h00, rv}, 16'h0051);
    w(3'h4, 8'h40);
    $display("done t_rdy");
  endtask : t_rdy

  task automatic t_pre;
    w(3'h4, 8'h40 + 8'h80);
    chk({14'h0000, prescale_alt}, 16'h0001);
    w(3'h4, 8'hC0 & 8'h7F);
    chk({14'h0000, prescale_alt}, 16'h0000);
    w(3'h3, 8'hBF);
    w(3'h2, 8'h00);
    w(3'h3, 8'h03);
    w(3'h4, 8'h80);
    chk({14'h0000, prescale_alt}, 16'h0000);
    $display("done t_pre");
  endtask : t_pre

  task automatic print_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (6) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    @(posedge mclk);
    t_div();
    t_gate();
    t_ext();
    t_tlr();
    t_rdy();
    t_pre();
    print_verdict();
  end

  initial
  begin
    #60000;
    errors++;
    print_verdict();
  end
endmodule : tb_top
